/* File: hdl/ssl_pkg.sv */
// Constants and types for the soft strap configuration loader
// Notes on behaviour
// [RULE1] Register bits act as virtual strap pins
// [RULE2] Software writes straps first, then done bit
// [RULE3] Reset sequence waits until done bit set
// [RULE4] Done causes one reset pulse and capture
// [RULE5] Bit 14 enables automatic crossover, resets 1
// [RULE6] Decode enable and mode into forced/advertised
// [RULE7] Latch decode into mode and advert registers
// [RULE8] Bit 10 picks layout one, else control
// [RULE9] Indicator layout bit latched at reset
// [RULE10] Done bit reads zero after hard reset
package ssl_pkg;
    // Register indices; each register is one word, so byte address is 4x
    localparam int          SSL_IDX_STRAP    = 'h9;
    localparam int          SSL_IDX_MODE     = 'h0;
    localparam int          SSL_IDX_ADVERT   = 'h4;
    localparam int          SSL_IDX_IND      = 'h18;
    localparam int          SSL_IDX_STATUS   = 'h40;
    localparam logic [11:0] SSL_OFS_STRAP    = 12'(SSL_IDX_STRAP * 4);
    localparam logic [11:0] SSL_OFS_MODE     = 12'(SSL_IDX_MODE * 4);
    localparam logic [11:0] SSL_OFS_ADVERT   = 12'(SSL_IDX_ADVERT * 4);
    localparam logic [11:0] SSL_OFS_IND      = 12'(SSL_IDX_IND * 4);
    localparam logic [11:0] SSL_OFS_STATUS   = 12'(SSL_IDX_STATUS * 4);
    localparam int          SSL_POS_DONE     = 15;
    localparam int          SSL_POS_MDIX     = 14;
    localparam int          SSL_POS_AUTONEG  = 13;
    localparam int          SSL_POS_MODE_HI  = 12;
    localparam int          SSL_POS_MODE_LO  = 11;
    localparam int          SSL_POS_LAYOUT   = 10;
    localparam logic [15:0] SSL_STRAP_RESET  = 16'h7c00;
    localparam logic [15:0] SSL_STRAP_WMASK  = 16'hfc00;
    localparam logic [15:0] SSL_IND_WMASK    = 16'h0060;
    localparam logic [3:0]  SSL_PULSE_CYCLES = 4'h4;

    typedef struct packed {
        logic       autoneg_enable;
        logic       speed_100;
        logic       full_duplex;
    } ssl_mode_t;

    typedef struct packed {
        logic       adv_100_full;
        logic       adv_100_half;
        logic       adv_10_full;
        logic       adv_10_half;
    } ssl_advert_t;

    typedef struct packed {
        logic        mdix_enable;
        ssl_mode_t   mode;
        ssl_advert_t advert;
        logic        layout_one;
    } ssl_cfg_t;
endpackage : ssl_pkg

/* File: hdl/ssl_loader.sv */
// Soft strap loader: APB register, reset hold, strap capture and decode
`timescale 1ns/1ps
`default_nettype none
module ssl_loader
    import ssl_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Device side
    output logic             int_reset_pulse,
    output logic             reset_done,
    output ssl_cfg_t         cfg,
    output logic [1:0]       indicator_mode
);
    typedef enum logic [1:0] {ST_WAIT, ST_PULSE, ST_DONE} ssl_state_t;

    ssl_state_t  state, next_state;
    logic [15:0] soft_strap_control_1, next_strap;
    logic [15:0] indicator_control_reg, next_ind;
    logic [3:0]  pulse_cnt, next_pulse_cnt;
    ssl_cfg_t    next_cfg;
    logic [31:0] next_prdata;
    logic        next_slverr;
    logic        wr, rd, hit;
    logic [15:0] wdat;

    assign wr     = psel && penable && pwrite;
    // Read data and error load at the setup edge, so they stand through
    // the access cycle that pready closes
    assign rd     = psel && !penable && !pwrite;
    assign pready = 1'b1;
    assign wdat   = {pstrb[1] ? pwdata[15:8] : 8'h00,
                     pstrb[0] ? pwdata[7:0]  : 8'h00};

    function automatic ssl_mode_t dec_mode(input logic [15:0] s);
        ssl_mode_t m;
        m.autoneg_enable = s[SSL_POS_AUTONEG];
        m.speed_100      = s[SSL_POS_MODE_HI];
        m.full_duplex    = s[SSL_POS_MODE_LO];
        return m;
    endfunction : dec_mode

    function automatic ssl_advert_t dec_adv(input logic [15:0] s);
        ssl_advert_t a;
        logic [1:0]  sel;
        sel = {s[SSL_POS_MODE_HI], s[SSL_POS_MODE_LO]};
        a   = '0;
        if (s[SSL_POS_AUTONEG]) begin
            unique case (sel) // RULE6
                2'h0: a = 4'h3;
                2'h1: a = 4'hc;
                2'h2: a = 4'h5;
                2'h3: a = 4'hf;
            endcase
        end else begin
            unique case (sel) // RULE6
                2'h0: a = 4'h1;
                2'h1: a = 4'h2;
                2'h2: a = 4'h4;
                2'h3: a = 4'h8;
            endcase
        end
        return a;
    endfunction : dec_adv

    // Register writes and read mux
    always_comb begin
        next_strap  = soft_strap_control_1;
        next_ind    = indicator_control_reg;
        next_prdata = prdata;
        next_slverr = 1'b0;
        hit = (paddr == SSL_OFS_STRAP) || (paddr == SSL_OFS_MODE) ||
              (paddr == SSL_OFS_ADVERT) || (paddr == SSL_OFS_IND) ||
              (paddr == SSL_OFS_STATUS);
        if (psel && !penable && !hit)
            next_slverr = 1'b1;
        if (wr && paddr == SSL_OFS_STRAP) begin
            // Straps are frozen once captured; only a hard reset reopens
            if (state == ST_WAIT)
                next_strap = wdat & SSL_STRAP_WMASK; // RULE1
        end
        if (wr && paddr == SSL_OFS_IND)
            next_ind = wdat & SSL_IND_WMASK; // RULE8
        if (rd) begin
            unique case (paddr)
                SSL_OFS_STRAP:  next_prdata = {16'h0000, soft_strap_control_1};
                SSL_OFS_MODE:   next_prdata = {29'h0, cfg.mode};
                SSL_OFS_ADVERT: next_prdata = {28'h0, cfg.advert};
                SSL_OFS_IND:    next_prdata = {16'h0000, indicator_control_reg};
                SSL_OFS_STATUS: next_prdata = {30'h0, reset_done,
                                               int_reset_pulse};
                default:        next_prdata = 32'h0000_0000;
            endcase
        end
    end

    // Reset sequence: hold, pulse, capture
    always_comb begin
        next_state     = state;
        next_pulse_cnt = pulse_cnt;
        next_cfg       = cfg;
        unique case (state)
            ST_WAIT: begin
                if (soft_strap_control_1[SSL_POS_DONE]) begin // RULE3
                    next_state     = ST_PULSE; // RULE4
                    next_pulse_cnt = SSL_PULSE_CYCLES;
                end
            end
            ST_PULSE: begin
                next_pulse_cnt = pulse_cnt - 4'h1;
                if (pulse_cnt == 4'h1) begin
                    next_state = ST_DONE;
                    next_cfg.mdix_enable = soft_strap_control_1[SSL_POS_MDIX]; // RULE5
                    next_cfg.mode   = dec_mode(soft_strap_control_1); // RULE7
                    next_cfg.advert = dec_adv(soft_strap_control_1);  // RULE7
                    next_cfg.layout_one =
                        soft_strap_control_1[SSL_POS_LAYOUT]; // RULE9
                end
            end
            ST_DONE: begin
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            soft_strap_control_1  <= SSL_STRAP_RESET; // RULE10
            indicator_control_reg <= 16'h0000;
            state                 <= ST_WAIT;
            pulse_cnt             <= 4'h0;
            cfg                   <= '0;
            prdata                <= 32'h0000_0000;
            pslverr               <= 1'b0;
        end else begin
            soft_strap_control_1  <= next_strap;
            indicator_control_reg <= next_ind;
            state                 <= next_state;
            pulse_cnt             <= next_pulse_cnt;
            cfg                   <= next_cfg;
            prdata                <= next_prdata;
            pslverr               <= next_slverr;
        end
    end

    assign int_reset_pulse = (state == ST_PULSE); // RULE4
    assign reset_done      = (state == ST_DONE);  // RULE3
    // Layout one = 2'h1; otherwise 2 or 3 from control bit 5
    assign indicator_mode  = cfg.layout_one ? 2'h1 :
                             (indicator_control_reg[5] ? 2'h3 : 2'h2); // RULE8
endmodule : ssl_loader
`default_nettype wire

/* File: tb/ssl_loader_properties.sv */
// Port checker for the soft strap loader
`timescale 1ns/1ps
`default_nettype none
module ssl_loader_properties
    import ssl_pkg::*;
(
    // Clock and reset
    input wire logic       pclk,
    input wire logic       presetn,
    // Device side
    input wire logic       int_reset_pulse,
    input wire logic       reset_done,
    input wire ssl_cfg_t   cfg,
    input wire logic [1:0] indicator_mode
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_pulse_len:
    assert property ($rose(int_reset_pulse) |-> int_reset_pulse[*4]
        ##1 !int_reset_pulse) else $error("pulse length");
    a_single_pulse:
    assert property ($fell(int_reset_pulse) |-> !int_reset_pulse[*8])
        else $error("pulse");
    a_done_holds:
    assert property (reset_done |=> reset_done) else $error("done");
    a_done_follows:
    assert property ($fell(int_reset_pulse) |-> ##[0:1] reset_done)
        else $error("no done");
    a_cfg_frozen:
    assert property (reset_done |=> $stable(cfg)) else $error("cfg moved");
    a_cfg_waits:
    assert property (!reset_done |-> cfg == '0) else $error("early cfg");
    a_layout_map:
    assert property (reset_done |-> (indicator_mode == 2'h1)
        == cfg.layout_one) else $error("layout");
    a_forced_one:
    assert property (reset_done && !cfg.mode.autoneg_enable
        |-> $onehot(cfg.advert)) else $error("forced");
endmodule : ssl_loader_properties
bind ssl_loader ssl_loader_properties u_props (.pclk, .presetn,
    .int_reset_pulse, .reset_done, .cfg, .indicator_mode);
`default_nettype wire

/* File: tb/ssl_apb_master.sv */
// APB master standing in for the system processor
`timescale 1ns/1ps
`default_nettype none
module ssl_apb_master (
    // Clock
    input  wire logic        pclk,
    // APB
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata,
    output logic [3:0]       pstrb,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    logic [31:0] rdat;
    logic        rerr;
    logic        tmo = 1'b0;
    initial {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d);
        int n;
        n = 0;
        {psel, pwrite, paddr, pwdata, pstrb} <= {1'b1, w, a, d, 4'h3};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50) begin
            n++;
            @(posedge pclk);
        end
        // Answer is taken at the edge that sees pready high
        rdat = (n < 50) ? prdata : 'x;
        rerr = pslverr;
        if (n >= 50)
            tmo = 1'b1;
        {psel, penable} <= 2'b0;
        // One idle edge so a following call never reassigns psel at once
        @(posedge pclk);
    endtask : xfer
endmodule : ssl_apb_master
`default_nettype wire

/* File: tb/ssl_loader_tb_top.sv */
// Self-checking bench for the soft strap loader
`timescale 1ns/1ps
`default_nettype none
module ssl_loader_tb_top;
    import ssl_pkg::*;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel, penable, pwrite, pready, pslverr;
    logic        int_reset_pulse, reset_done;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  pstrb;
    logic [1:0]  indicator_mode;
    ssl_cfg_t    cfg;
    logic [15:0] v;
    int          n_fail = 0;
    int          comparisons = 0;
    int          np;
    // Advert per {enable, mode}: forced sets one bit, negotiated sets two, or all four for mode 3
    logic [3:0]  adt [8] = '{4'h1, 4'h2, 4'h4, 4'h8,
                             4'h3, 4'hc, 4'h5, 4'hf};
    always #50 pclk = ~pclk;
    ssl_loader uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb, .prdata, .pready, .pslverr, .int_reset_pulse,
        .reset_done, .cfg, .indicator_mode);
    ssl_apb_master mst (.pclk, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb, .prdata, .pready, .pslverr);
    task automatic check(input string what, input logic [31:0] e, g);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask : check
    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop
    // A transfer that never completes counts as a mismatch
    always @(posedge pclk) begin
        if (mst.tmo) begin
            n_fail++;
            report_and_stop();
        end
    end
    initial begin
        for (int i = 0; i < 8; i++) begin
            presetn <= 1'b0;
            repeat (10) @(posedge pclk);
            presetn <= 1'b1;
            @(posedge pclk);
            mst.xfer(1'b0, SSL_OFS_STRAP, 32'h0);
            check("strap", 32'h7c00, mst.rdat);
            v = {1'b0, i[0], i[2:0], i[1], 10'h0};
            mst.xfer(1'b1, SSL_OFS_STRAP, {16'h0, v});
            repeat (3) @(posedge pclk);
            check("wait", 0, {int_reset_pulse, reset_done});
            v[15] = 1'b1;
            mst.xfer(1'b1, SSL_OFS_STRAP, {16'h0, v});
            np = 0;
            for (int k = 0; k < 20 && reset_done !== 1'b1; k++) begin
                @(posedge pclk);
                np += int_reset_pulse;
            end
            if (reset_done !== 1'b1) begin
                n_fail++;
                report_and_stop();
            end
            check("pulse", 4, np);
            check("advert", adt[i], cfg.advert);
            check("straps", {i[0], i[2], i[1]}, {cfg.mdix_enable,
                cfg.mode.autoneg_enable, cfg.layout_one});
            check("mode", {i[2], i[1], i[0]}, cfg.mode);
            mst.xfer(1'b0, SSL_OFS_ADVERT, 32'h0);
            check("advert reg", adt[i], mst.rdat);
            mst.xfer(1'b0, SSL_OFS_STATUS, 32'h0);
            check("status", 2, mst.rdat);
            check("layout", i[1] ? 1 : 2, indicator_mode);
            mst.xfer(1'b1, SSL_OFS_IND, 32'h60);
            check("layout3", i[1] ? 1 : 3, indicator_mode);
            // Late writes must not disturb the latched straps
            mst.xfer(1'b1, SSL_OFS_STRAP, 32'h0);
            mst.xfer(1'b0, SSL_OFS_STRAP, 32'h0);
            check("locked", {16'h0, v}, mst.rdat);
            $display("test %0d done", i);
        end
        mst.xfer(1'b0, 12'h200, 32'h0);
        check("slverr", 1, mst.rerr);
        report_and_stop();
    end
endmodule : ssl_loader_tb_top
`default_nettype wire
